// ### rtl/uhi_regs.svh
// Register offsets, field positions and reset values of the interrupt status block
`ifndef UHI_REGS_SVH
`define UHI_REGS_SVH
`define UHI_ADDR_W        32
`define UHI_OFS_STATUS    32'h8002000c
`define UHI_OFS_EN_SET    32'h80020010
`define UHI_OFS_EN_CLR    32'h80020014
`define UHI_OFS_BASE      32'h80020018
`define UHI_OFS_PERIOD    32'h8002001c
`define UHI_OFS_OVR_CNT   32'h80020040
`define UHI_BIT_OVERRUN   0
`define UHI_BIT_WRITEBACK 1
`define UHI_BIT_FRAME     2
`define UHI_BIT_RESUME    3
`define UHI_BIT_FATAL     4
`define UHI_BIT_WRAP      5
`define UHI_BIT_HUB       6
`define UHI_BIT_OWNER     30
`define UHI_BIT_MASTER    31
`define UHI_FLAG_MASK     32'h4000007f
`define UHI_EN_MASK       32'hc000007f
`define UHI_BASE_MASK     32'hffffff00
`define UHI_PTR_MASK      32'hfffffff0
`define UHI_RESET_VAL     32'h00000000
`endif

// ### rtl/uhi_pkg.sv
// Types shared by the interrupt status block
package uhi_pkg;
  typedef logic [31:0] uhi_word_t;
  typedef logic [1:0]  uhi_count_t;
endpackage : uhi_pkg

// ### rtl/uhi_irq_status.sv
// Interrupt status, enables, shared area base and periodic pointer of a USB host controller
`timescale 1ns/1ps
`include "uhi_regs.svh"

module uhi_irq_status
  import uhi_pkg::*;
#(
  parameter bit HAS_SMI_PIN = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        softReset,
  input  wire logic [31:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regRdData,
  input  wire logic        overrunEvent,
  input  wire logic        frameCountWritten,
  input  wire logic        doneHeadWritten,
  input  wire logic        frameStart,
  input  wire logic [15:0] frameCount,
  input  wire logic        deviceResume,
  input  wire logic        resumeStateBySw,
  input  wire logic        systemError,
  input  wire logic        hubChange,
  input  wire logic        ownershipRequest,
  input  wire logic        irqRoutingSelect,
  input  wire logic        periodicDone,
  input  wire logic [31:0] periodicDescriptor,
  output logic             busIrq,
  output logic             systemMgmtIrq,
  output logic             sofToken,
  output logic             doneHeadWriteAllowed,
  output logic             haltProcessing,
  output logic [31:0]      sharedAreaBase,
  output logic [1:0]       overrunCounter
);

  uhi_word_t  flags_reg;
  uhi_word_t  flags_next;
  uhi_word_t  enable_reg;
  uhi_word_t  enable_next;
  uhi_word_t  base_reg;
  uhi_word_t  period_reg;
  uhi_count_t ovrCnt_reg;
  logic       resume_reg;
  logic       msb_reg;
  logic       busIrq_reg;
  logic       smi_reg;
  logic       sof_reg;
  logic       dhAllowed_reg;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // Decoded write strobes
  wire logic wrStatus = regWrite && hit(regAddr, `UHI_OFS_STATUS);
  wire logic wrEnSet  = regWrite && hit(regAddr, `UHI_OFS_EN_SET);
  wire logic wrEnClr  = regWrite && hit(regAddr, `UHI_OFS_EN_CLR);
  wire logic wrBase   = regWrite && hit(regAddr, `UHI_OFS_BASE);

  // Frame-count related events wait for the shared-area update strobe
  wire logic overrunSet = overrunEvent && frameCountWritten;
  wire logic frameSet   = frameStart && frameCountWritten;
  wire logic wrapSet    = frameCountWritten && (frameCount[15] != msb_reg);
  // Software entering resume itself gives no edge
  wire logic resumeSet  = deviceResume && !resume_reg && !resumeStateBySw;
  wire logic ownerSet   = ownershipRequest && HAS_SMI_PIN;
  // No token goes out while a fatal error holds the controller
  wire logic sofGo      = frameSet && !flags_reg[`UHI_BIT_FATAL];

  uhi_word_t setVec;
  assign setVec = (32'(overrunSet) << `UHI_BIT_OVERRUN)
                | (32'(doneHeadWritten && doneHeadWriteAllowed) << `UHI_BIT_WRITEBACK)
                | (32'(frameSet) << `UHI_BIT_FRAME)
                | (32'(resumeSet) << `UHI_BIT_RESUME)
                | (32'(systemError) << `UHI_BIT_FATAL)
                | (32'(wrapSet) << `UHI_BIT_WRAP)
                | (32'(hubChange) << `UHI_BIT_HUB)
                | (32'(ownerSet) << `UHI_BIT_OWNER);

  // Set has priority over a write-one clear in the same cycle
  wire uhi_word_t clrVec = wrStatus ? regWrData : '0;
  assign flags_next = ((flags_reg & ~clrVec) | setVec) & `UHI_FLAG_MASK;

  // Writing zero never touches an enable; disable wins over set in the same cycle
  assign enable_next = ((enable_reg | (wrEnSet ? regWrData : '0))
                        & ~(wrEnClr ? regWrData : '0)) & `UHI_EN_MASK;

  wire logic anyPending = |(flags_reg & enable_reg & `UHI_FLAG_MASK);
  wire logic irqActive  = enable_reg[`UHI_BIT_MASTER] && anyPending;
  wire logic ownerNow   = flags_reg[`UHI_BIT_OWNER] && enable_reg[`UHI_BIT_OWNER];

  // Read mux; unmapped and reserved bits read as zero
  uhi_word_t rdMux;
  always_comb begin
    rdMux = '0;
    if (hit(regAddr, `UHI_OFS_STATUS)) begin
      rdMux = flags_reg;
    end else if (hit(regAddr, `UHI_OFS_EN_SET) || hit(regAddr, `UHI_OFS_EN_CLR)) begin
      rdMux = enable_reg;
    end else if (hit(regAddr, `UHI_OFS_BASE)) begin
      rdMux = base_reg;
    end else if (hit(regAddr, `UHI_OFS_PERIOD)) begin
      rdMux = period_reg;
    end else if (hit(regAddr, `UHI_OFS_OVR_CNT)) begin
      rdMux = {30'h0, ovrCnt_reg};
    end
  end

  // Software reset clears the status and enables but keeps the base pointer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_reg  <= `UHI_RESET_VAL;
      enable_reg <= `UHI_RESET_VAL;
      ovrCnt_reg <= 2'h0;
      resume_reg <= 1'b0;
      msb_reg    <= 1'b0;
    end else if (clkEn) begin
      flags_reg  <= softReset ? `UHI_RESET_VAL : flags_next;
      enable_reg <= softReset ? `UHI_RESET_VAL : enable_next;
      if (softReset) begin
        ovrCnt_reg <= 2'h0;
      end else if (overrunSet) begin
        ovrCnt_reg <= ovrCnt_reg + 2'h1;
      end
      resume_reg <= deviceResume;
      if (frameCountWritten) begin
        msb_reg <= frameCount[15];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      base_reg   <= `UHI_RESET_VAL;
      period_reg <= `UHI_RESET_VAL;
    end else if (clkEn) begin
      if (wrBase) begin
        base_reg <= regWrData & `UHI_BASE_MASK;
      end
      if (periodicDone) begin
        period_reg <= periodicDescriptor & `UHI_PTR_MASK;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdData  <= `UHI_RESET_VAL;
      busIrq_reg <= 1'b0;
      smi_reg    <= 1'b0;
      sof_reg    <= 1'b0;
    end else if (clkEn) begin
      regRdData  <= regRead ? rdMux : '0;
      busIrq_reg <= irqActive && !irqRoutingSelect;
      smi_reg    <= (irqActive && irqRoutingSelect) || ownerNow;
      sof_reg    <= sofGo;
    end
  end

  // Own flop so the permission pin is a register output, not an inverter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dhAllowed_reg <= 1'b1;
    end else if (clkEn) begin
      dhAllowed_reg <= softReset || !flags_next[`UHI_BIT_WRITEBACK];
    end
  end

  assign busIrq               = busIrq_reg;
  assign systemMgmtIrq        = smi_reg;
  assign sofToken             = sof_reg;
  assign doneHeadWriteAllowed = dhAllowed_reg;
  assign haltProcessing       = flags_reg[`UHI_BIT_FATAL];
  assign sharedAreaBase       = base_reg;
  assign overrunCounter       = ovrCnt_reg;

  // Checks
  AST_OVR_FLAG: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && overrunSet |=> flags_reg[`UHI_BIT_OVERRUN])
    else $error("overrun flag not set");
  AST_OVR_CNT: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && overrunSet |=> ovrCnt_reg == $past(ovrCnt_reg) + 2'h1)
    else $error("overrun counter did not step");
  AST_WB_HOLD: assert property (@(posedge clock) disable iff (rst)
    flags_reg[`UHI_BIT_WRITEBACK] |-> !doneHeadWriteAllowed)
    else $error("done head write allowed while flag set");
  AST_SOF: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && frameSet && !flags_reg[`UHI_BIT_FATAL]
    |=> sofToken && flags_reg[`UHI_BIT_FRAME])
    else $error("frame start without token");
  AST_RESUME: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && !flags_reg[`UHI_BIT_RESUME] && !resumeSet
    |=> !flags_reg[`UHI_BIT_RESUME])
    else $error("resume flag set without edge");
  AST_HALT: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && systemError |=> haltProcessing)
    else $error("fatal error did not halt");
  AST_OWNER0: assert property (@(posedge clock) disable iff (rst)
    !HAS_SMI_PIN |-> !flags_reg[`UHI_BIT_OWNER])
    else $error("ownership flag set without pin");
  AST_MASTER0: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && wrEnSet && !regWrData[`UHI_BIT_MASTER] && enable_reg[`UHI_BIT_MASTER]
    |=> enable_reg[`UHI_BIT_MASTER])
    else $error("zero write cleared master enable");
  AST_DISABLE: assert property (@(posedge clock) disable iff (rst)
    clkEn && wrEnClr && regWrData[`UHI_BIT_MASTER] |=> !enable_reg[`UHI_BIT_MASTER])
    else $error("disable did not clear master");
  AST_SET_WINS: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && wrStatus && systemError |=> flags_reg[`UHI_BIT_FATAL])
    else $error("clear beat set");
  AST_IRQ: assert property (@(posedge clock) disable iff (rst)
    clkEn && irqActive && !irqRoutingSelect |=> busIrq)
    else $error("bus irq missing");
  AST_NO_IRQ: assert property (@(posedge clock) disable iff (rst)
    clkEn && irqRoutingSelect |=> !busIrq)
    else $error("bus irq while routed to smi");
  AST_BASE: assert property (@(posedge clock) disable iff (rst)
    clkEn && wrBase |=> sharedAreaBase == ($past(regWrData) & `UHI_BASE_MASK))
    else $error("base not stored");
  AST_OVR_GATE: assert property (@(posedge clock) disable iff (rst)
    clkEn && !frameCountWritten && !flags_reg[`UHI_BIT_OVERRUN]
    |=> !flags_reg[`UHI_BIT_OVERRUN])
    else $error("overrun flag set without frame count write");
  AST_WB_ONCE: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && !wrStatus && flags_reg[`UHI_BIT_WRITEBACK]
    |=> flags_reg[`UHI_BIT_WRITEBACK])
    else $error("writeback flag dropped without clear");
  AST_FRAME_GATE: assert property (@(posedge clock) disable iff (rst)
    clkEn && !frameCountWritten |=> !sofToken)
    else $error("token without frame count write");
  AST_RESUME_SET: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && resumeSet |=> flags_reg[`UHI_BIT_RESUME])
    else $error("resume edge not flagged");
  AST_HALT_SOF: assert property (@(posedge clock) disable iff (rst)
    clkEn && flags_reg[`UHI_BIT_FATAL] |=> !sofToken)
    else $error("token sent while halted");
  AST_WRAP: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && wrapSet |=> flags_reg[`UHI_BIT_WRAP])
    else $error("frame wrap not flagged");
  AST_HUB: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && hubChange |=> flags_reg[`UHI_BIT_HUB])
    else $error("hub change not flagged");
  AST_OWNER: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && ownerSet |=> flags_reg[`UHI_BIT_OWNER])
    else $error("ownership request not flagged");
  AST_SMI: assert property (@(posedge clock) disable iff (rst)
    clkEn && ownerNow |=> systemMgmtIrq)
    else $error("ownership change gave no smi");
  AST_EN_SET: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && wrEnSet
    |=> (enable_reg & $past(regWrData) & `UHI_EN_MASK) == ($past(regWrData) & `UHI_EN_MASK))
    else $error("enable not set");
  AST_MASTER1: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && wrEnSet && regWrData[`UHI_BIT_MASTER] |=> enable_reg[`UHI_BIT_MASTER])
    else $error("master enable not set");
  AST_DIS_KEEP: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && wrEnClr && !regWrData[`UHI_BIT_HUB] && enable_reg[`UHI_BIT_HUB]
    |=> enable_reg[`UHI_BIT_HUB])
    else $error("zero disable bit cleared enable");
  AST_SMI_ROUTE: assert property (@(posedge clock) disable iff (rst)
    clkEn && irqActive && irqRoutingSelect |=> systemMgmtIrq)
    else $error("routed irq missing on smi");
  AST_BASE_KEEP: assert property (@(posedge clock) disable iff (rst)
    clkEn && !wrBase |=> sharedAreaBase == $past(sharedAreaBase))
    else $error("base changed without write");
  AST_PERIOD: assert property (@(posedge clock) disable iff (rst)
    clkEn && periodicDone |=> period_reg == ($past(periodicDescriptor) & `UHI_PTR_MASK))
    else $error("periodic pointer not loaded");
  AST_RSVD: assert property (@(posedge clock) disable iff (rst)
    clkEn && regRead && hit(regAddr, `UHI_OFS_STATUS)
    |=> (regRdData & ~`UHI_FLAG_MASK) == '0)
    else $error("reserved status bits not zero");
  AST_CLEAR: assert property (@(posedge clock) disable iff (rst)
    clkEn && !softReset && wrStatus && setVec == '0
    |=> (flags_reg & $past(regWrData)) == '0)
    else $error("write one did not clear flag");
  AST_NO_IRQ0: assert property (@(posedge clock) disable iff (rst)
    clkEn && !irqActive && !ownerNow |=> !busIrq && !systemMgmtIrq)
    else $error("irq without enabled pending flag");

  COV_IRQ:    cover property (@(posedge clock) disable iff (rst) busIrq);
  COV_SMI:    cover property (@(posedge clock) disable iff (rst) systemMgmtIrq);
  COV_WRAP:   cover property (@(posedge clock) disable iff (rst) ovrCnt_reg == 2'h3 ##1 ovrCnt_reg == 2'h0);
  COV_SETCLR: cover property (@(posedge clock) disable iff (rst) wrStatus && |setVec);
  COV_HALT:   cover property (@(posedge clock) disable iff (rst) haltProcessing && frameSet);

endmodule : uhi_irq_status

// ### dv/uhi_frame_src.sv
// Frame event source standing in for the controller core beside the status block
`timescale 1ns/1ps
module uhi_frame_src #(
  parameter logic [15:0] START = 16'h7ffd
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        late,
  output logic             fcWritten,
  output logic             fStart,
  output logic             overrun,
  output logic      [15:0] fCount
);
  // Frame number lands with the write pulse, so flags never see a stale count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fcWritten <= 1'b0;
      fStart    <= 1'b0;
      overrun   <= 1'b0;
      fCount    <= START;
    end else begin
      fcWritten <= go;
      fStart    <= go;
      overrun   <= go & late;
      if (go) begin
        fCount <= fCount + 16'h0001;
      end
    end
  end
endmodule : uhi_frame_src

// ### dv/usb_host_irq_status_enable_bench.sv
// Self-checking bench for the interrupt status block
`timescale 1ns/1ps
`include "uhi_regs.svh"
module usb_host_irq_status_enable_bench;
  import uhi_pkg::*;
  logic        clock, rst, rgW, rgR, go, late, devRes, resSw, sysErr, route, sr, ce;
  logic [3:0]  ev;
  uhi_word_t   addr, wdat, rdat, desc, base, v;
  logic        bIrq, system_mgmt_irq, sof, dhOk, halt, fcw, fs, ovr;
  logic [15:0] fc;
  logic [1:0]  ovrCnt;
  int          bad_count, n_compared, cyc, sofSeen;

  uhi_irq_status dut (.clock(clock), .rst(rst), .clkEn(ce), .softReset(sr),
    .regAddr(addr), .regWrData(wdat), .regWrite(rgW), .regRead(rgR), .regRdData(rdat),
    .overrunEvent(ovr), .frameCountWritten(fcw), .doneHeadWritten(ev[2]), .frameStart(fs),
    .frameCount(fc), .deviceResume(devRes), .resumeStateBySw(resSw), .systemError(sysErr),
    .hubChange(ev[0]), .ownershipRequest(ev[1]), .irqRoutingSelect(route),
    .periodicDone(ev[3]), .periodicDescriptor(desc), .busIrq(bIrq), .systemMgmtIrq(system_mgmt_irq),
    .sofToken(sof), .doneHeadWriteAllowed(dhOk), .haltProcessing(halt),
    .sharedAreaBase(base), .overrunCounter(ovrCnt));
  uhi_frame_src frames (.clock(clock), .rst(rst), .go(go), .late(late), .fcWritten(fcw),
    .fStart(fs), .overrun(ovr), .fCount(fc));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // Ceiling well above the roughly 120 cycles the sequence needs
  always @(posedge clock) begin
    cyc++;
    if (sof === 1'b1) sofSeen++;
    if (cyc == 3000) begin
      bad_count++;
      $display("BAD %0t timeout", $time);
      summarize();
    end
  end

  task chk(input uhi_word_t got, input uhi_word_t exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input uhi_word_t a, input uhi_word_t d);
    @(posedge clock);
    rgW <= 1'b1; addr <= a; wdat <= d;
    @(posedge clock);
    rgW <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task rc(input uhi_word_t a, input uhi_word_t exp);
    @(posedge clock);
    rgR <= 1'b1; addr <= a;
    @(posedge clock);
    rgR <= 1'b0;
    #1 chk(rdat, exp);
  endtask : rc
  task pulse(input logic [3:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 4'h0;
  endtask : pulse

  initial begin
    rst = 1; rgW = 0; rgR = 0; go = 0; late = 0; devRes = 0; resSw = 0; sysErr = 0;
    route = 0; sr = 0; ev = 0; addr = 0; wdat = 0; desc = 32'h1234567f; ce = 1;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) rc(`UHI_OFS_STATUS + 4 * i, 32'h0);
    rc(32'h80020044, 32'h0);
    $display("reset values done");
    wr(`UHI_OFS_EN_SET, 32'hffffffff);
    rc(`UHI_OFS_EN_SET, 32'hc000007f);
    wr(`UHI_OFS_EN_CLR, 32'h0000003f);
    rc(`UHI_OFS_EN_CLR, 32'hc0000040);
    wr(`UHI_OFS_EN_SET, 32'h0);
    rc(`UHI_OFS_EN_SET, 32'hc0000040);
    wr(`UHI_OFS_BASE, 32'hffffffff);
    rc(`UHI_OFS_BASE, 32'hffffff00);
    chk(base, 32'hffffff00);
    $display("enables done");
    pulse(4'h1);
    rc(`UHI_OFS_STATUS, 32'h40);
    chk({31'h0, bIrq}, 32'h1);
    route <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk({30'h0, bIrq, system_mgmt_irq}, 32'h1);
    route <= 1'b0;
    @(posedge clock);
    ev <= 4'h1; rgW <= 1'b1; addr <= `UHI_OFS_STATUS; wdat <= 32'h40;
    @(posedge clock);
    ev <= 4'h0; rgW <= 1'b0;
    rc(`UHI_OFS_STATUS, 32'h40);
    wr(`UHI_OFS_STATUS, 32'h40);
    rc(`UHI_OFS_STATUS, 32'h0);
    chk({31'h0, bIrq}, 32'h0);
    $display("hub change done");
    pulse(4'h2);
    rc(`UHI_OFS_STATUS, 32'h40000000);
    chk({31'h0, system_mgmt_irq}, 32'h1);
    wr(`UHI_OFS_STATUS, 32'h40000000);
    pulse(4'h4);
    #1 chk({31'h0, dhOk}, 32'h0);
    rc(`UHI_OFS_STATUS, 32'h2);
    wr(`UHI_OFS_STATUS, 32'h2);
    #1 chk({31'h0, dhOk}, 32'h1);
    pulse(4'h8);
    rc(`UHI_OFS_PERIOD, 32'h12345670);
    $display("sources done");
    @(posedge clock);
    resSw <= 1'b1; devRes <= 1'b1;
    repeat (2) @(posedge clock);
    resSw <= 1'b0; devRes <= 1'b0;
    rc(`UHI_OFS_STATUS, 32'h0);
    devRes <= 1'b1;
    rc(`UHI_OFS_STATUS, 32'h8);
    devRes <= 1'b0;
    wr(`UHI_OFS_STATUS, 32'h8);
    @(posedge clock);
    go <= 1'b1; late <= 1'b1;
    repeat (5) @(posedge clock);
    go <= 1'b0; late <= 1'b0;
    repeat (2) @(posedge clock);
    rc(`UHI_OFS_STATUS, 32'h25);
    chk({30'h0, ovrCnt}, 32'h1);
    rc(`UHI_OFS_OVR_CNT, 32'h1);
    chk(sofSeen, 32'h5);
    $display("frames done");
    @(posedge clock);
    sysErr <= 1'b1;
    @(posedge clock);
    sysErr <= 1'b0;
    #1 chk({31'h0, halt}, 32'h1);
    rc(`UHI_OFS_STATUS, 32'h35);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    repeat (3) @(posedge clock);
    chk(sofSeen, 32'h5);
    sr <= 1'b1;
    @(posedge clock);
    sr <= 1'b0;
    rc(`UHI_OFS_STATUS, 32'h0);
    rc(`UHI_OFS_EN_SET, 32'h0);
    $display("fatal error done");
    ce <= 1'b0;
    pulse(4'h1);
    ce <= 1'b1;
    rc(`UHI_OFS_STATUS, 32'h0);
    $display("clock enable done");
    summarize();
  end
endmodule : usb_host_irq_status_enable_bench
